// File: shared/rtc_pkg.sv
// shared constants of the periodic wakeup timer
package rtc_pkg;
  // ==========
  // register byte offsets
  localparam logic [3:0] OFF_PROT  = 4'h0;
  localparam logic [3:0] OFF_CTRL  = 4'h4;
  localparam logic [3:0] OFF_FLAGS = 4'h8;
  localparam logic [3:0] OFF_COUNT = 4'hC;
  // ==========
  // access_protection fields
  localparam int PROT_SUP_BIT = 0;
  // ==========
  // timer_control fields
  localparam int CTL_CNT_EN  = 31;
  localparam int CTL_MIE     = 30;
  localparam int CTL_FRZ     = 29;
  localparam int CTL_ROV_EN  = 28;
  localparam int CTL_MVAL_HI = 27;
  localparam int CTL_MVAL_LO = 16;
  localparam int CTL_PER_EN  = 15;
  localparam int CTL_PIE     = 14;
  localparam int CTL_SEL_HI  = 13;
  localparam int CTL_SEL_LO  = 12;
  localparam int CTL_D512    = 11;
  localparam int CTL_D32     = 10;
  localparam int CTL_PVAL_HI = 9;
  localparam int CTL_PVAL_LO = 0;
  // ==========
  // event_flags fields
  localparam int FLG_MATCH = 2;
  localparam int FLG_PER   = 1;
  localparam int FLG_ROV   = 0;
  // ==========
  // reset values and match window
  localparam logic [31:0] CTRL_RST  = 32'h0000_0000;
  localparam logic        PROT_RST  = 1'b0;
  localparam int          MWIN_LO   = 10;
  localparam int          MWIN_HI   = 21;
  localparam logic [31:0] CNT_MAX   = 32'hFFFF_FFFF;
  // ==========
  // clock source codes and divider ratios
  localparam logic [1:0] SRC_SLOW_XTAL = 2'h0;
  localparam logic [1:0] SRC_SLOW_RC   = 2'h1;
  localparam logic [1:0] SRC_FAST_RC   = 2'h2;
  localparam logic [1:0] SRC_FAST_XTAL = 2'h3;
  localparam int         DIV_A         = 512;
  localparam int         DIV_B         = 32;
  // ==========
  // periodic engine states
  typedef enum logic [1:0] {PW_IDLE, PW_SYNC, PW_RUN} rtc_pw_e;
endpackage

// File: logic/rtc_prescaler.sv
// clock source selection and optional dividers
`timescale 1ns/10ps
`default_nettype none
module rtc_prescaler (
  // clock and reset
  input  wire logic       clock,
  input  wire logic       resetn,
  // configuration
  input  wire logic       enable,
  input  wire logic [1:0] sel,
  input  wire logic       div_a_en,
  input  wire logic       div_b_en,
  // source ticks
  input  wire logic       slow_crystal_osc,
  input  wire logic       slow_internal_rc,
  input  wire logic       fast_internal_rc,
  input  wire logic       fast_crystal_osc,
  // counter tick
  output logic            tick_q
);
  import rtc_pkg::*;

  logic       raw;
  logic       ta;
  logic       tb;
  logic [8:0] ca_q;
  logic [4:0] cb_q;

  function automatic logic at_end(input logic [8:0] c, input int n);
    at_end = (c == 9'(n - 1));
  endfunction

  // ==========
  // source mux
  always_comb begin
    case (sel)
      SRC_SLOW_XTAL: raw = slow_crystal_osc;
      SRC_SLOW_RC:   raw = slow_internal_rc;
      SRC_FAST_RC:   raw = fast_internal_rc;
      default:       raw = fast_crystal_osc;
    endcase
  end

  // ==========
  // dividers
  assign ta = raw & (!div_a_en | at_end(ca_q, DIV_A));
  assign tb = ta & (!div_b_en | at_end({4'h0, cb_q}, DIV_B));

  always_ff @(posedge clock) begin
    if (!resetn || !enable) begin
      ca_q <= '0;
    end else if (raw && div_a_en) begin
      ca_q <= ca_q + 9'h1;
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn || !enable) begin
      cb_q <= '0;
    end else if (ta && div_b_en) begin
      cb_q <= cb_q + 5'h1;
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn || !enable) begin
      tick_q <= 1'b0;
    end else begin
      tick_q <= tb;
    end
  end

  a_gate_off: assert property (@(posedge clock) disable iff (!resetn)
    !enable |=> !tick_q) else $error("tick while disabled");
endmodule // rtc_prescaler
`default_nettype wire

// File: logic/rtc_periodic.sv
// periodic wakeup engine with offset target
`timescale 1ns/10ps
`default_nettype none
module rtc_periodic #(
  parameter int IW = 10
) (
  // clock and reset
  input  wire logic          clock,
  input  wire logic          resetn,
  // control
  input  wire logic          run,
  input  wire logic          tick,
  input  wire logic [31:0]   cnt,
  input  wire logic [IW-1:0] interval,
  // event
  output logic               event_q
);
  import rtc_pkg::*;

  rtc_pw_e       st_q;
  logic [IW-1:0] iv_q;
  logic [31:0]   tgt_q;

  // ==========
  // interval sync, target and event
  always_ff @(posedge clock) begin
    event_q <= 1'b0;
    if (!resetn || !run) begin
      st_q  <= PW_IDLE;
      iv_q  <= '0;
      tgt_q <= '0;
    end else if (tick) begin
      case (st_q)
        PW_IDLE: begin
          if (interval != '0) begin
            iv_q <= interval;
            st_q <= PW_SYNC;
          end
        end
        PW_SYNC: begin
          tgt_q <= cnt + 32'(iv_q);
          st_q  <= PW_RUN;
        end
        default: begin
          if (cnt == tgt_q) begin
            event_q <= 1'b1;
            tgt_q   <= tgt_q + 32'(iv_q) + 32'h1;
          end
        end
      endcase
    end
  end

  a_zero_idle: assert property (@(posedge clock) disable iff (!resetn)
    (st_q == PW_IDLE && interval == '0) |=> st_q == PW_IDLE && !event_q)
    else $error("periodic ran with zero interval");
  a_period_step: assert property (@(posedge clock) disable iff (!resetn || !run)
    (st_q == PW_RUN && tick && cnt == tgt_q) |=> tgt_q == $past(tgt_q) + 32'($past(iv_q)) + 32'h1)
    else $error("periodic target not advanced by interval plus one");
endmodule // rtc_periodic
`default_nettype wire

// File: logic/rtc_timer.sv
// wakeup timer top: counter, compare, flags, registers
`timescale 1ns/10ps
`default_nettype none
module rtc_timer (
  // clock and power-on reset
  input  wire logic                 clock,
  input  wire logic                 resetn,
  // register port
  input  wire logic [3:0]           addr,
  input  wire logic [31:0]          wdata,
  input  wire logic                 wr_stb,
  input  wire logic                 rd_stb,
  input  wire logic                 supervisor,
  output logic [31:0]               rdata_q,
  output logic                      access_err_q,
  // counter clock source ticks
  input  wire logic                 slow_crystal_osc,
  input  wire logic                 slow_internal_rc,
  input  wire logic                 fast_internal_rc,
  input  wire logic                 fast_crystal_osc,
  // device modes
  input  wire logic                 debug_mode,
  input  wire logic                 low_power_mode,
  // requests
  output logic                      match_irq_q,
  output logic                      periodic_irq_q,
  output logic                      wakeup_req_q
);
  import rtc_pkg::*;

  // ==========
  // state
  logic        supervisor_only_q;
  logic        counter_enable_q;
  logic        match_irq_enable_q;
  logic        debug_freeze_enable_q;
  logic        rollover_enable_q;
  logic [11:0] match_value_q;
  logic        periodic_enable_q;
  logic        periodic_irq_enable_q;
  logic [1:0]  clock_select_q;
  logic        div_by_512_enable_q;
  logic        div_by_32_enable_q;
  logic [9:0]  periodic_interval_q;
  logic        match_flag_q;
  logic        periodic_flag_q;
  logic        rollover_flag_q;
  logic [31:0] cnt_q;
  logic [31:0] cnt_rd_q;
  logic        match_prev_q;
  logic        match_pend_q;
  logic        per_pend_q;

  // ==========
  // combinational
  logic        tick;
  logic        tick_run;
  logic        per_ev;
  logic        match_hit;
  logic        match_ev;
  logic        rov_ev;
  logic        match_set;
  logic        per_set;
  logic        wr_ok;
  logic        rd_ok;
  logic        wr_ctrl;
  logic        wr_flags;
  logic [31:0] ctrl_word;
  logic [31:0] flag_word;

  // ==========
  // access decode
  function automatic logic allowed(input logic [3:0] a, input logic sup,
                                   input logic prot, input logic lp);
    if (lp || a[1:0] != 2'h0) begin
      allowed = 1'b0;
    end else if (a == OFF_PROT) begin
      allowed = sup;
    end else begin
      allowed = sup || !prot;
    end
  endfunction

  assign wr_ok    = wr_stb && allowed(addr, supervisor, supervisor_only_q, low_power_mode);
  assign rd_ok    = rd_stb && allowed(addr, supervisor, supervisor_only_q, low_power_mode);
  assign wr_ctrl  = wr_ok && addr == OFF_CTRL;
  assign wr_flags = wr_ok && addr == OFF_FLAGS;

  always_comb begin
    ctrl_word = '0;
    ctrl_word[CTL_CNT_EN]              = counter_enable_q;
    ctrl_word[CTL_MIE]                 = match_irq_enable_q;
    ctrl_word[CTL_FRZ]                 = debug_freeze_enable_q;
    ctrl_word[CTL_ROV_EN]              = rollover_enable_q;
    ctrl_word[CTL_MVAL_HI:CTL_MVAL_LO] = match_value_q;
    ctrl_word[CTL_PER_EN]              = periodic_enable_q;
    ctrl_word[CTL_PIE]                 = periodic_irq_enable_q;
    ctrl_word[CTL_SEL_HI:CTL_SEL_LO]   = clock_select_q;
    ctrl_word[CTL_D512]                = div_by_512_enable_q;
    ctrl_word[CTL_D32]                 = div_by_32_enable_q;
    ctrl_word[CTL_PVAL_HI:CTL_PVAL_LO] = periodic_interval_q;
  end

  always_comb begin
    flag_word            = '0;
    flag_word[FLG_MATCH] = match_flag_q;
    flag_word[FLG_PER]   = periodic_flag_q;
    flag_word[FLG_ROV]   = rollover_flag_q;
  end

  // ==========
  // configuration registers, power-on reset only
  always_ff @(posedge clock) begin
    if (!resetn) begin
      supervisor_only_q <= PROT_RST;
    end else if (wr_ok && addr == OFF_PROT) begin
      supervisor_only_q <= wdata[PROT_SUP_BIT];
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      counter_enable_q      <= CTRL_RST[CTL_CNT_EN];
      match_irq_enable_q    <= CTRL_RST[CTL_MIE];
      debug_freeze_enable_q <= CTRL_RST[CTL_FRZ];
      rollover_enable_q     <= CTRL_RST[CTL_ROV_EN];
      match_value_q         <= CTRL_RST[CTL_MVAL_HI:CTL_MVAL_LO];
      periodic_enable_q     <= CTRL_RST[CTL_PER_EN];
      periodic_irq_enable_q <= CTRL_RST[CTL_PIE];
      clock_select_q        <= CTRL_RST[CTL_SEL_HI:CTL_SEL_LO];
      div_by_512_enable_q   <= CTRL_RST[CTL_D512];
      div_by_32_enable_q    <= CTRL_RST[CTL_D32];
      periodic_interval_q   <= CTRL_RST[CTL_PVAL_HI:CTL_PVAL_LO];
    end else if (wr_ctrl) begin
      counter_enable_q      <= wdata[CTL_CNT_EN];
      match_irq_enable_q    <= wdata[CTL_MIE];
      debug_freeze_enable_q <= wdata[CTL_FRZ];
      rollover_enable_q     <= wdata[CTL_ROV_EN];
      match_value_q         <= wdata[CTL_MVAL_HI:CTL_MVAL_LO];
      periodic_enable_q     <= wdata[CTL_PER_EN];
      periodic_irq_enable_q <= wdata[CTL_PIE];
      // source, dividers and interval are expected stable while running
      clock_select_q        <= wdata[CTL_SEL_HI:CTL_SEL_LO];
      div_by_512_enable_q   <= wdata[CTL_D512];
      div_by_32_enable_q    <= wdata[CTL_D32];
      periodic_interval_q   <= wdata[CTL_PVAL_HI:CTL_PVAL_LO];
    end
  end

  // ==========
  // tick generation and periodic engine
  rtc_prescaler u_presc (
    .clock            (clock),
    .resetn           (resetn),
    .enable           (counter_enable_q),
    .sel              (clock_select_q),
    .div_a_en         (div_by_512_enable_q),
    .div_b_en         (div_by_32_enable_q),
    .slow_crystal_osc (slow_crystal_osc),
    .slow_internal_rc (slow_internal_rc),
    .fast_internal_rc (fast_internal_rc),
    .fast_crystal_osc (fast_crystal_osc),
    .tick_q           (tick)
  );

  assign tick_run = tick && !(debug_mode && debug_freeze_enable_q);

  rtc_periodic #(.IW(10)) u_per (
    .clock    (clock),
    .resetn   (resetn),
    .run      (counter_enable_q && periodic_enable_q),
    .tick     (tick_run),
    .cnt      (cnt_q),
    .interval (periodic_interval_q),
    .event_q  (per_ev)
  );

  // ==========
  // free-running counter
  always_ff @(posedge clock) begin
    if (!resetn || !counter_enable_q) begin
      cnt_q <= '0;
    end else if (tick_run) begin
      cnt_q <= cnt_q + 32'h1;
    end
  end

  // read copy, lags the live count by one cycle at most
  always_ff @(posedge clock) begin
    if (!resetn) begin
      cnt_rd_q <= '0;
    end else begin
      cnt_rd_q <= cnt_q;
    end
  end

  // ==========
  // match and rollover detection
  assign match_hit = counter_enable_q && cnt_q[MWIN_HI:MWIN_LO] == match_value_q;
  assign match_ev  = match_hit && !match_prev_q;
  assign rov_ev    = tick_run && cnt_q == CNT_MAX;

  always_ff @(posedge clock) begin
    if (!resetn || !counter_enable_q) begin
      match_prev_q <= 1'b0;
    end else begin
      match_prev_q <= match_hit;
    end
  end

  // low power match and periodic events flag one cycle after their wakeup
  always_ff @(posedge clock) begin
    if (!resetn || !counter_enable_q) begin
      match_pend_q <= 1'b0;
      per_pend_q   <= 1'b0;
    end else begin
      match_pend_q <= match_ev && low_power_mode;
      per_pend_q   <= per_ev && low_power_mode;
    end
  end

  assign match_set = (match_ev && !low_power_mode) || match_pend_q;
  assign per_set   = (per_ev && !low_power_mode) || per_pend_q;

  // ==========
  // sticky flags, set wins over clear
  always_ff @(posedge clock) begin
    if (!resetn) begin
      match_flag_q <= 1'b0;
    end else if (match_set) begin
      match_flag_q <= 1'b1;
    end else if (wr_flags && wdata[FLG_MATCH]) begin
      match_flag_q <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      periodic_flag_q <= 1'b0;
    end else if (per_set) begin
      periodic_flag_q <= 1'b1;
    end else if (wr_flags && wdata[FLG_PER]) begin
      periodic_flag_q <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      rollover_flag_q <= 1'b0;
    end else if (rov_ev) begin
      rollover_flag_q <= 1'b1;
    end else if (wr_flags && wdata[FLG_ROV]) begin
      rollover_flag_q <= 1'b0;
    end
  end

  // ==========
  // requests
  always_ff @(posedge clock) begin
    if (!resetn) begin
      wakeup_req_q <= 1'b0;
    end else begin
      wakeup_req_q <= match_ev || per_ev || (rov_ev && rollover_enable_q);
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      match_irq_q <= 1'b0;
    end else begin
      match_irq_q <= match_irq_enable_q && (match_flag_q || (rollover_flag_q && rollover_enable_q));
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      periodic_irq_q <= 1'b0;
    end else begin
      periodic_irq_q <= periodic_irq_enable_q && periodic_flag_q;
    end
  end

  // ==========
  // register read port
  always_ff @(posedge clock) begin
    if (!resetn) begin
      rdata_q <= '0;
    end else if (!rd_ok) begin
      rdata_q <= '0;
    end else if (addr == OFF_PROT) begin
      rdata_q <= {31'h0, supervisor_only_q};
    end else if (addr == OFF_CTRL) begin
      rdata_q <= ctrl_word;
    end else if (addr == OFF_FLAGS) begin
      rdata_q <= flag_word;
    end else begin
      rdata_q <= cnt_rd_q;
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      access_err_q <= 1'b0;
    end else begin
      access_err_q <= (wr_stb && !wr_ok) || (rd_stb && !rd_ok);
    end
  end

  // ==========
  // checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);

  sequence s_wake_then_flag;
    wakeup_req_q ##1 match_flag_q;
  endsequence

  a_counter_clear: assert property (
    !counter_enable_q |=> cnt_q == 32'h0) else $error("counter not cleared");
  a_counter_step: assert property (
    (counter_enable_q && tick_run) |=> cnt_q == $past(cnt_q) + 32'h1)
    else $error("counter did not advance");
  a_freeze_hold: assert property (
    (debug_mode && debug_freeze_enable_q) |=> cnt_q == $past(cnt_q) || cnt_q == 32'h0)
    else $error("counter moved while frozen");
  a_match_flag: assert property (
    (match_ev && !low_power_mode) |=> match_flag_q) else $error("match flag not set");
  a_lp_wake_first: assert property (
    (match_ev && low_power_mode) |=> s_wake_then_flag) else $error("low power match order");
  a_match_irq_off: assert property (
    !match_irq_enable_q |=> !match_irq_q) else $error("match irq while disabled");
  a_rov_wake: assert property (
    (rov_ev && rollover_enable_q) |=> wakeup_req_q && rollover_flag_q)
    else $error("rollover did not wake");
  a_w1c_clear: assert property (
    (wr_flags && wdata[FLG_MATCH] && !match_set) |=> !match_flag_q)
    else $error("match flag not cleared");
  a_zero_keeps: assert property (
    (wr_flags && !wdata[FLG_PER] && periodic_flag_q) |=> periodic_flag_q)
    else $error("periodic flag lost on zero write");
  a_lp_no_write: assert property (
    (wr_stb && low_power_mode) |=> ctrl_word == $past(ctrl_word))
    else $error("write taken in low power");
  a_prot_block: assert property (
    (wr_stb && supervisor_only_q && !supervisor && addr == OFF_CTRL) |=> ctrl_word == $past(ctrl_word) && access_err_q)
    else $error("user write passed protection");
  a_per_irq: assert property (
    (periodic_flag_q && periodic_irq_enable_q) |=> periodic_irq_q)
    else $error("periodic irq missing");
endmodule // rtc_timer
`default_nettype wire

// File: logic/rtc_unused_placeholder_none.sv
// intentionally empty design unit list terminator
`timescale 1ns/10ps
`default_nettype none
`default_nettype wire

// File: testbench/rtc_src_model.sv
// source tick generator and wakeup unit model for the timer bench
`timescale 1ns/10ps
`default_nettype none
module rtc_src_model (
  // clock and reset
  input  wire logic        clock,
  input  wire logic        resetn,
  // wakeup request from the timer
  input  wire logic        wakeup_req,
  // ticks: bit0 slow crystal, bit1 slow rc, bit2 fast rc, bit3 fast crystal
  output logic [3:0]       osc
);
  logic [3:0]  free_mask = 4'h0;
  logic [3:0]  burst_mask = 4'h0;
  logic [15:0] gap_q;
  logic [15:0] last_gap;
  int          wake_cnt;
  // burst sources tick for one cycle and idle low between ticks; free_mask sources stay high every cycle
  always @(posedge clock) begin
    if (!resetn) begin
      osc <= 4'h0;
    end else begin
      osc <= free_mask | burst_mask;
    end
  end
  // wakeup unit side: counts requests and the cycle gap between them
  always @(posedge clock) begin
    if (!resetn) begin
      gap_q    <= 16'h0;
      last_gap <= 16'h0;
      wake_cnt <= 0;
    end else if (wakeup_req) begin
      last_gap <= gap_q + 16'h1;
      gap_q    <= 16'h0;
      wake_cnt <= wake_cnt + 1;
    end else begin
      gap_q <= gap_q + 16'h1;
    end
  end
  // burst of n ticks on the sources in m: one tick every second cycle
  task automatic burst(input logic [3:0] m, input int n);
    repeat (n) begin
      @(posedge clock) burst_mask <= m;
      @(posedge clock) burst_mask <= 4'h0;
    end
  endtask
endmodule // rtc_src_model
`default_nettype wire

// File: testbench/rtc_timer_tb.sv
// self-checking bench for the periodic wakeup timer
`timescale 1ns/10ps
`default_nettype none
`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin err_total++; \
  $display("MISMATCH t=%0t got %0h exp %0h", $time, got, exp); end end
module rtc_timer_tb;
  import rtc_pkg::*;
  localparam logic [31:0] EN   = 32'h1 << CTL_CNT_EN;
  localparam logic [31:0] MIE  = 32'h1 << CTL_MIE;
  localparam logic [31:0] FRZ  = 32'h1 << CTL_FRZ;
  localparam logic [31:0] PEN  = 32'h1 << CTL_PER_EN;
  localparam logic [31:0] PIE  = 32'h1 << CTL_PIE;
  localparam logic [31:0] D512 = 32'h1 << CTL_D512;
  localparam logic [31:0] D32  = 32'h1 << CTL_D32;
  localparam logic [31:0] MFF  = 32'hFFF << CTL_MVAL_LO;
  localparam logic [31:0] SEL3 = 32'(SRC_FAST_XTAL) << CTL_SEL_LO;
  localparam logic [31:0] CFG  = EN | (32'h1 << CTL_MVAL_LO) | SEL3;
  logic        clock = 1'b0;
  logic        resetn = 1'b0;
  logic [3:0]  addr = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic        wr_stb = 1'b0;
  logic        rd_stb = 1'b0;
  logic        supervisor = 1'b1;
  logic        debug_mode = 1'b0;
  logic        low_power_mode = 1'b0;
  logic [31:0] rdata_q;
  logic        access_err_q;
  logic        match_irq_q;
  logic        periodic_irq_q;
  logic        wakeup_req_q;
  logic [3:0]  osc;
  logic [31:0] d;
  logic [31:0] d2;
  logic        last_err;
  int          err_total = 0;
  int          n_compared = 0;
  int          w0;
  always #50 clock = ~clock;
  // ==========
  // design and partner
  rtc_timer i_dut (.clock(clock), .resetn(resetn), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
    .rd_stb(rd_stb), .supervisor(supervisor), .rdata_q(rdata_q), .access_err_q(access_err_q),
    .slow_crystal_osc(osc[0]), .slow_internal_rc(osc[1]), .fast_internal_rc(osc[2]),
    .fast_crystal_osc(osc[3]), .debug_mode(debug_mode), .low_power_mode(low_power_mode),
    .match_irq_q(match_irq_q), .periodic_irq_q(periodic_irq_q), .wakeup_req_q(wakeup_req_q));
  rtc_src_model i_src (.clock(clock), .resetn(resetn), .wakeup_req(wakeup_req_q), .osc(osc));
  // ==========
  // register port tasks
  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge clock);
    addr   <= a;
    wdata  <= v;
    wr_stb <= 1'b1;
    @(posedge clock);
    wr_stb <= 1'b0;
    #1 last_err = access_err_q;
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] v);
    @(posedge clock);
    addr   <= a;
    rd_stb <= 1'b1;
    @(posedge clock);
    rd_stb <= 1'b0;
    #1 v = rdata_q;
    last_err = access_err_q;
  endtask
  task automatic end_sim;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (30000) @(posedge clock);
    err_total++;
    end_sim();
  end
  // ==========
  // tests
  initial begin
    repeat (4) @(posedge clock);
    resetn <= 1'b1;
    rd(OFF_PROT, d); `CHK(d, {31'h0, PROT_RST})
    rd(OFF_CTRL, d); `CHK(d, CTRL_RST)
    rd(OFF_FLAGS, d); `CHK(d, 32'h0)
    rd(4'h2, d); `CHK(d, 32'h0)
    `CHK(last_err, 1'b1)
    // each source alone drives the counter, divided by 32
    for (int s = 0; s < 4; s++) begin
      wr(OFF_CTRL, MFF | D32 | (32'(s) << CTL_SEL_LO));
      wr(OFF_CTRL, EN | MFF | D32 | (32'(s) << CTL_SEL_LO));
      i_src.burst(4'h1 << s, 64);
      i_src.burst(~(4'h1 << s), 96);
      repeat (4) @(posedge clock);
      rd(OFF_COUNT, d); `CHK(d, 32'd2)
      wr(OFF_CTRL, MFF);
      repeat (3) @(posedge clock);
      rd(OFF_COUNT, d); `CHK(d, 32'd0)
    end
    wr(OFF_CTRL, EN | MFF | D512 | SEL3);
    i_src.burst(4'h8, 1024);
    repeat (4) @(posedge clock);
    rd(OFF_COUNT, d); `CHK(d, 32'd2)
    wr(OFF_CTRL, MFF | SEL3);
    // match on counter bits 21:10, value changed while running
    wr(OFF_FLAGS, 32'h7);
    w0 = i_src.wake_cnt;
    wr(OFF_CTRL, EN | MIE | MFF | SEL3);
    @(posedge clock) i_src.free_mask <= 4'h8;
    wr(OFF_CTRL, CFG | MIE);
    for (int i = 0; i < 1300 && match_irq_q !== 1'b1; i++) @(posedge clock);
    `CHK(match_irq_q, 1'b1)
    `CHK(i_src.wake_cnt - w0, 1)
    rd(OFF_FLAGS, d); `CHK(d, 32'h1 << FLG_MATCH)
    wr(OFF_FLAGS, 32'h0);
    rd(OFF_FLAGS, d); `CHK(d, 32'h1 << FLG_MATCH)
    wr(OFF_FLAGS, 32'h1 << FLG_MATCH);
    rd(OFF_FLAGS, d); `CHK(d, 32'h0)
    repeat (2) @(posedge clock);
    `CHK(match_irq_q, 1'b0)
    // debug freeze holds the count and resumes from it
    wr(OFF_CTRL, CFG | FRZ);
    @(posedge clock) debug_mode <= 1'b1;
    repeat (4) @(posedge clock);
    rd(OFF_COUNT, d);
    rd(OFF_COUNT, d2); `CHK(d2, d)
    @(posedge clock) debug_mode <= 1'b0;
    repeat (4) @(posedge clock);
    rd(OFF_COUNT, d2); `CHK(d2 > d, 1'b1)
    `CHK(d2 - d < 32'd20, 1'b1)
    // low power refuses the register port
    @(posedge clock) low_power_mode <= 1'b1;
    wr(OFF_CTRL, 32'h0); `CHK(last_err, 1'b1)
    @(posedge clock) low_power_mode <= 1'b0;
    rd(OFF_CTRL, d); `CHK(d, CFG | FRZ)
    // supervisor-only protection
    wr(OFF_PROT, 32'h1);
    @(posedge clock) supervisor <= 1'b0;
    rd(OFF_CTRL, d); `CHK(d, 32'h0)
    `CHK(last_err, 1'b1)
    wr(OFF_PROT, 32'h0); `CHK(last_err, 1'b1)
    @(posedge clock) supervisor <= 1'b1;
    rd(OFF_PROT, d); `CHK(d, 32'h1)
    wr(OFF_PROT, 32'h0);
    // without freeze the count keeps running in debug mode
    wr(OFF_CTRL, CFG);
    @(posedge clock) debug_mode <= 1'b1;
    rd(OFF_COUNT, d);
    repeat (4) @(posedge clock);
    rd(OFF_COUNT, d2); `CHK(d2 - d, 32'd6)
    @(posedge clock) debug_mode <= 1'b0;
    // zero interval keeps the periodic engine quiet
    w0 = i_src.wake_cnt;
    wr(OFF_CTRL, CFG | PEN);
    repeat (40) @(posedge clock);
    `CHK(i_src.wake_cnt, w0)
    // interval 4 repeats every 5 counts
    wr(OFF_CTRL, CFG | 32'd4);
    wr(OFF_CTRL, CFG | PEN | PIE | 32'd4);
    repeat (40) @(posedge clock);
    `CHK(i_src.last_gap, 16'd5)
    `CHK(periodic_irq_q, 1'b1)
    rd(OFF_FLAGS, d); `CHK(d[FLG_PER], 1'b1)
    // low power match: wakeup first, flag one cycle later
    wr(OFF_CTRL, MFF | SEL3);
    wr(OFF_FLAGS, 32'h7);
    w0 = i_src.wake_cnt;
    fork
      wr(OFF_CTRL, EN | MIE | SEL3);
      begin
        @(posedge clock);
        @(posedge clock) low_power_mode <= 1'b1;
      end
    join
    @(posedge clock);
    #1 `CHK(wakeup_req_q, 1'b1)
    @(posedge clock);
    #1 `CHK(match_irq_q, 1'b0)
    @(posedge clock);
    #1 `CHK(match_irq_q, 1'b1)
    `CHK(i_src.wake_cnt - w0, 1)
    end_sim();
  end
endmodule // rtc_timer_tb
`default_nettype wire
